/* File: hw/mbsp_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the segment packer
// Assumes: 32-bit APB data, one aligned word per register
// Notes: included by bare name; definitions only
`ifndef MBSP_CFG_SVH
`define MBSP_CFG_SVH

// register byte addresses
`define MBSP_OFS_CTRL 12'h000
`define MBSP_OFS_BLOCK 12'h004
`define MBSP_OFS_STATUS 12'h008
`define MBSP_OFS_TUNE 12'h00C
`define MBSP_OFS_WORDS 12'h010

// control register fields and block field width
`define MBSP_CTRL_START 0
`define MBSP_CTRL_DIR 1
`define MBSP_CTRL_EQSEL 2
`define MBSP_BLOCK_W 4

// reset values
`define MBSP_RST_DIR 1'b0
`define MBSP_RST_EQSEL 1'b0
`define MBSP_RST_BLOCK 4'h0

// control word layout on the user-k port
`define MBSP_CW_SINGLE 0
`define MBSP_CW_SEG_LO 1
`define MBSP_CW_DIR 3
`define MBSP_CW_BLK_LO 4

// load request setup time
`define MBSP_SETUP_NS 300
`define MBSP_CLK_NS 100
`define MBSP_SETUP_CYC ((`MBSP_SETUP_NS + `MBSP_CLK_NS - 1) / `MBSP_CLK_NS)

`endif

/* File: hw/mbsp_pkg.sv */
// Purpose: types shared by the segment packer files
// Assumes: nothing
// Notes: constants live in mbsp_cfg.svh
package mbsp_pkg;
	typedef enum logic [2:0]
	{
		MBSP_IDLE = 3'b000,
		MBSP_WAIT_LOAD = 3'b001,
		MBSP_CTRL = 3'b010,
		MBSP_DATA = 3'b011,
		MBSP_DRAIN = 3'b100,
		MBSP_LOADREQ = 3'b101
	} mbsp_state_t;

	typedef enum logic
	{
		MBSP_DIR_INC = 1'b0,
		MBSP_DIR_DEC = 1'b1
	} mbsp_dir_t;
endpackage

/* File: hw/mbsp_fifo.sv */
// Purpose: word FIFO between the packer and streaming channel 0
// Assumes: single clock, DEPTH a power of two
// Notes: full and empty from pointers with a wrap bit
`timescale 1ns/1ps
`default_nettype none
module mbsp_fifo #(
	parameter int WIDTH = 192,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("mbsp_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;

	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wr_q <= '0;
		else if (in_valid && !full)
			wr_q <= wr_q + 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_q <= '0;
		else if (out_ready && !empty)
			rd_q <= rd_q + 1'b1;
	end
endmodule
`default_nettype wire

/* File: hw/mbsp_setup_timer.sv */
// Purpose: counts the least time from first data word to load request
// Assumes: start is a one-cycle pulse
// Notes: done stays high until clear
`timescale 1ns/1ps
`default_nettype none
module mbsp_setup_timer #(
	parameter int CYCLES = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic clear,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);

	initial
	begin
		if (CYCLES < 1)
			$error("mbsp_setup_timer: CYCLES must be at least 1");
	end

	logic [CW-1:0] cnt_q;
	logic run_q;

	assign done = run_q && (cnt_q == CW'(CYCLES));

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			run_q <= 1'b0;
			cnt_q <= '0;
		end
		else if (clear)
		begin
			run_q <= 1'b0;
			cnt_q <= '0;
		end
		else if (start)
		begin
			run_q <= 1'b1;
			cnt_q <= CW'(1);
		end
		else if (run_q && !done)
			cnt_q <= cnt_q + 1'b1;
	end
endmodule
`default_nettype wire

/* File: hw/mbsp_packer.sv */
// Purpose: single-channel block framer; packs block rows into bus words per segment
// Assumes: row source answers a row request in any later cycle; tuning inputs static
// Notes: segments 3,2,1,0 each send control word, full block data, load request
// Summary of operation
// - each block goes as segments 3,2,1,0: control word, data, load request
// - channels 1 to 3 stay idle; everything travels on channel 0
// - block is 1024 columns by 136 rows of one-bit pixels
// - block packs into 726 192-bit words: 725 full, last one partial
// - last word carries pixels in bits 0-63 only; upper bits are don't care
// - rows packed back to back; crossing word has old row low, new row high
// - increment direction starts at row 0 column 0, rows ascending
// - decrement direction starts at row 135 column 0, rows descending
// - five-bit post-emphasis tuning input exposed, reference value zero
// - four-bit swing tuning input exposed, reference value 1000
// - seven-bit main-tap and five-bit pre-emphasis inputs, reference zero
// - control word single-channel flag set to one
// - load request no sooner than 300 ns after first data word sent
// - only the channel 0 serial links are used
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mbsp_cfg.svh"
module mbsp_packer #(
	parameter int COLS = 1024,
	parameter int ROWS = 136,
	parameter int WORD_W = 192,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic row_req_valid,
	output logic [7:0] row_req_index,
	output logic [1:0] row_req_segment,
	input wire logic row_rsp_valid,
	input wire logic [COLS-1:0] row_rsp_data,
	output logic ctrl_k_valid,
	output logic [WORD_W-1:0] ctrl_k_data,
	input wire logic ctrl_k_ready,
	output logic ch0_tvalid,
	output logic [WORD_W-1:0] ch0_tdata,
	input wire logic ch0_tready,
	output logic ch1_tvalid,
	output logic [WORD_W-1:0] ch1_tdata,
	output logic ch2_tvalid,
	output logic [WORD_W-1:0] ch2_tdata,
	output logic ch3_tvalid,
	output logic [WORD_W-1:0] ch3_tdata,
	output logic load_req,
	input wire logic block_loading_n,
	output logic [1:0] segment_index,
	output logic rx_equalizer_select,
	input wire logic [4:0] tx_post_emphasis,
	input wire logic [3:0] tx_swing_setting,
	input wire logic [6:0] tx_main_tap,
	input wire logic [4:0] tx_pre_emphasis,
	output logic [4:0] xcvr_post_emphasis,
	output logic [3:0] xcvr_swing_setting,
	output logic [6:0] xcvr_main_tap,
	output logic [4:0] xcvr_pre_emphasis
);
	import mbsp_pkg::*;

	localparam int WORDS = (COLS * ROWS + WORD_W - 1) / WORD_W;
	localparam int PW = $clog2(2 * COLS);
	localparam int WCW = $clog2(WORDS + 1);

	initial
	begin
		if (COLS < WORD_W || ROWS < 2 || ROWS > 256)
			$error("mbsp_packer: COLS must reach WORD_W, ROWS must be 2..256");
	end

	mbsp_state_t state_q;
	logic dir_q;
	logic eqsel_q;
	logic [`MBSP_BLOCK_W-1:0] block_q;
	logic start_q;
	logic [1:0] seg_q;
	logic [COLS-1:0] cur_q;
	logic [COLS-1:0] nxt_q;
	logic cur_ok_q;
	logic nxt_ok_q;
	logic [8:0] fetched_q;
	logic [PW-1:0] pos_q;
	logic [WCW-1:0] word_q;
	logic first_q;
	logic [31:0] sent_q;
	logic [31:0] prdata_q;
	logic [2*COLS-1:0] window;
	logic [PW:0] pos_add;
	logic emit_valid;
	logic emit_ready;
	logic emit_fire;
	logic [WORD_W-1:0] emit_word;
	logic ch0_fire;
	logic fifo_empty;
	logic setup_done;
	logic wr_fire;
	logic rd_setup;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `MBSP_OFS_CTRL) || (a == `MBSP_OFS_BLOCK) || (a == `MBSP_OFS_STATUS)
			|| (a == `MBSP_OFS_TUNE) || (a == `MBSP_OFS_WORDS);
	endfunction

	// zero-wait-state slave; read data sampled in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign prdata = prdata_q;
	assign wr_fire = psel && penable && pwrite && mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			prdata_q <= 32'h0000_0000;
		else if (rd_setup)
		begin
			case (paddr)
				`MBSP_OFS_CTRL: prdata_q <= {29'h0, eqsel_q, dir_q, 1'b0};
				`MBSP_OFS_BLOCK: prdata_q <= {28'h0, block_q};
				`MBSP_OFS_STATUS: prdata_q <= {25'h0, state_q, block_loading_n, seg_q,
					state_q != MBSP_IDLE};
				`MBSP_OFS_TUNE: prdata_q <= {11'h0, tx_pre_emphasis, tx_main_tap,
					tx_swing_setting, tx_post_emphasis};
				`MBSP_OFS_WORDS: prdata_q <= sent_q;
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dir_q <= `MBSP_RST_DIR;
			eqsel_q <= `MBSP_RST_EQSEL;
			block_q <= `MBSP_RST_BLOCK;
		end
		else if (wr_fire && paddr == `MBSP_OFS_CTRL)
		begin
			dir_q <= pwdata[`MBSP_CTRL_DIR];
			eqsel_q <= pwdata[`MBSP_CTRL_EQSEL];
		end
		else if (wr_fire && paddr == `MBSP_OFS_BLOCK)
			block_q <= pwdata[`MBSP_BLOCK_W-1:0];
	end

	// start is a request pulse; ignored while a block is under way
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			start_q <= 1'b0;
		else
			start_q <= wr_fire && paddr == `MBSP_OFS_CTRL && pwdata[`MBSP_CTRL_START]
				&& state_q == MBSP_IDLE;
	end

	// static settings go straight to the transceiver, no resync needed
	assign xcvr_post_emphasis = tx_post_emphasis;
	assign xcvr_swing_setting = tx_swing_setting;
	assign xcvr_main_tap = tx_main_tap;
	assign xcvr_pre_emphasis = tx_pre_emphasis;
	assign rx_equalizer_select = eqsel_q;

	// unused channels held idle
	assign ch1_tvalid = 1'b0;
	assign ch1_tdata = '0;
	assign ch2_tvalid = 1'b0;
	assign ch2_tdata = '0;
	assign ch3_tvalid = 1'b0;
	assign ch3_tdata = '0;

	assign segment_index = seg_q;
	assign ch0_fire = ch0_tvalid && ch0_tready;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= MBSP_IDLE;
			seg_q <= 2'd3;
		end
		else
		begin
			case (state_q)
				MBSP_IDLE:
					if (start_q)
					begin
						state_q <= MBSP_WAIT_LOAD;
						seg_q <= 2'd3;
					end
				// a new block must not overrun the buffer still being loaded
				MBSP_WAIT_LOAD:
					if (block_loading_n)
						state_q <= MBSP_CTRL;
				// leave only once the control word was actually taken
				MBSP_CTRL:
					if (ctrl_k_valid && ctrl_k_ready)
						state_q <= MBSP_DATA;
				MBSP_DATA:
					if (emit_fire && word_q == WCW'(WORDS - 1))
						state_q <= MBSP_DRAIN;
				MBSP_DRAIN:
					if (fifo_empty && setup_done)
						state_q <= MBSP_LOADREQ;
				MBSP_LOADREQ:
				begin
					if (seg_q == 2'd0)
						state_q <= MBSP_IDLE;
					else
					begin
						state_q <= MBSP_CTRL;
						seg_q <= seg_q - 2'd1;
					end
				end
				default: state_q <= MBSP_IDLE;
			endcase
		end
	end

	// one pulse per segment; only segment 0's triggers the array load
	assign load_req = (state_q == MBSP_LOADREQ);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			ctrl_k_valid <= 1'b0;
		else if (state_q == MBSP_CTRL && ctrl_k_valid && ctrl_k_ready)
			ctrl_k_valid <= 1'b0;
		else if (state_q == MBSP_CTRL)
			ctrl_k_valid <= 1'b1;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			ctrl_k_data <= '0;
		else if (state_q == MBSP_CTRL && !ctrl_k_valid)
		begin
			ctrl_k_data <= '0;
			ctrl_k_data[`MBSP_CW_SINGLE] <= 1'b1;
			ctrl_k_data[`MBSP_CW_SEG_LO +: 2] <= seg_q;
			ctrl_k_data[`MBSP_CW_DIR] <= dir_q;
			ctrl_k_data[`MBSP_CW_BLK_LO +: `MBSP_BLOCK_W] <= block_q;
		end
	end

	// row fetch order follows the direction
	assign row_req_valid = (state_q == MBSP_DATA) && !nxt_ok_q && fetched_q < 9'(ROWS);
	assign row_req_index = (dir_q == MBSP_DIR_DEC) ? 8'(ROWS - 1 - fetched_q)
		: fetched_q[7:0];
	assign row_req_segment = seg_q;

	// two-row window: low bits of a crossing word from cur, high bits from nxt
	assign window = {nxt_q, cur_q};
	assign emit_word = window[pos_q +: WORD_W];
	assign emit_valid = (state_q == MBSP_DATA) && cur_ok_q
		&& (nxt_ok_q || fetched_q == 9'(ROWS));
	assign emit_fire = emit_valid && emit_ready;
	assign pos_add = {1'b0, pos_q} + (PW + 1)'(WORD_W);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cur_q <= '0;
			nxt_q <= '0;
			cur_ok_q <= 1'b0;
			nxt_ok_q <= 1'b0;
			fetched_q <= 9'd0;
			pos_q <= '0;
			word_q <= '0;
		end
		else if (state_q == MBSP_CTRL)
		begin
			cur_ok_q <= 1'b0;
			nxt_ok_q <= 1'b0;
			fetched_q <= 9'd0;
			pos_q <= '0;
			word_q <= '0;
		end
		else if (state_q == MBSP_DATA)
		begin
			if (row_req_valid && row_rsp_valid)
			begin
				nxt_q <= row_rsp_data;
				nxt_ok_q <= 1'b1;
				fetched_q <= fetched_q + 9'd1;
			end
			else if (!cur_ok_q && nxt_ok_q)
			begin
				cur_q <= nxt_q;
				cur_ok_q <= 1'b1;
				nxt_ok_q <= 1'b0;
			end
			else if (emit_fire)
			begin
				word_q <= word_q + 1'b1;
				if (pos_add >= (PW + 1)'(COLS))
				begin
					// row end crossed: no padding, continue in next row
					pos_q <= PW'(pos_add - (PW + 1)'(COLS));
					cur_q <= nxt_q;
					cur_ok_q <= nxt_ok_q;
					nxt_ok_q <= 1'b0;
				end
				else
					pos_q <= pos_add[PW-1:0];
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			first_q <= 1'b0;
		else if (state_q == MBSP_CTRL)
			first_q <= 1'b1;
		else if (ch0_fire)
			first_q <= 1'b0;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			sent_q <= 32'h0000_0000;
		else if (ch0_fire)
			sent_q <= sent_q + 32'h0000_0001;
	end

	mbsp_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst(sys_rst),
		.in_valid(emit_valid),
		.in_ready(emit_ready),
		.in_data(emit_word),
		.out_valid(ch0_tvalid),
		.out_ready(ch0_tready),
		.out_data(ch0_tdata),
		.empty(fifo_empty)
	);

	// measured from the first data word accepted on channel 0
	mbsp_setup_timer #(
		.CYCLES(`MBSP_SETUP_CYC)
	) u_setup (
		.clk(mclk),
		.rst(sys_rst),
		.start(ch0_fire && first_q),
		.clear(state_q == MBSP_CTRL),
		.done(setup_done)
	);
endmodule
`default_nettype wire

/* File: bench/mbsp_packer_checker.sv */
// Purpose: port-level checks of the segment packer
// Assumes: one clock domain, reset active high
// Notes: bound to every packer instance
`timescale 1ns/1ps
`default_nettype none
`include "mbsp_cfg.svh"
module mbsp_packer_checker #(
	parameter int WORD_W = 192
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ctrl_k_valid,
	input wire logic [WORD_W-1:0] ctrl_k_data,
	input wire logic ctrl_k_ready,
	input wire logic ch0_tvalid,
	input wire logic [WORD_W-1:0] ch0_tdata,
	input wire logic ch0_tready,
	input wire logic ch1_tvalid,
	input wire logic ch2_tvalid,
	input wire logic ch3_tvalid,
	input wire logic load_req,
	input wire logic [1:0] segment_index,
	input wire logic [4:0] tx_post_emphasis,
	input wire logic [3:0] tx_swing_setting,
	input wire logic [6:0] tx_main_tap,
	input wire logic [4:0] tx_pre_emphasis,
	input wire logic [4:0] xcvr_post_emphasis,
	input wire logic [3:0] xcvr_swing_setting,
	input wire logic [6:0] xcvr_main_tap,
	input wire logic [4:0] xcvr_pre_emphasis
);
	logic seen_q;
	logic [2:0] since_q;
	logic [1:0] seg_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// edges since first word of the transfer, saturating
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seen_q <= 1'b0;
			since_q <= 3'h0;
		end
		else if (load_req)
		begin
			seen_q <= 1'b0;
			since_q <= 3'h0;
		end
		else if ((ch0_tvalid && ch0_tready) || seen_q)
		begin
			seen_q <= 1'b1;
			since_q <= (since_q == 3'h7) ? 3'h7 : since_q + 3'h1;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			seg_q <= 2'h3;
		else if (load_req)
			seg_q <= seg_q - 2'h1;
	end
	ch_idle_a:
	assert property (!(ch1_tvalid || ch2_tvalid || ch3_tvalid)) else $error("spare channel busy");
	post_pass_a:
	assert property (xcvr_post_emphasis == tx_post_emphasis) else $error("post tap lost");
	swing_pass_a:
	assert property (xcvr_swing_setting == tx_swing_setting) else $error("swing lost");
	taps_pass_a:
	assert property (xcvr_main_tap == tx_main_tap && xcvr_pre_emphasis == tx_pre_emphasis)
		else $error("main or pre tap lost");
	load_pulse_a:
	assert property (load_req |=> !load_req) else $error("load request too long");
	load_setup_a:
	assert property (load_req |-> seen_q && since_q >= 3'h3 && !ch0_tvalid)
		else $error("load request too early");
	seg_order_a:
	assert property (load_req |-> segment_index == seg_q) else $error("segment out of order");
	ctrl_hold_a:
	assert property (ctrl_k_valid && !ctrl_k_ready |=> ctrl_k_valid && $stable(ctrl_k_data))
		else $error("control word dropped");
	ctrl_flag_a:
	assert property (ctrl_k_valid |-> ctrl_k_data[`MBSP_CW_SINGLE]
		&& ctrl_k_data[`MBSP_CW_SEG_LO +: 2] == segment_index) else $error("control word wrong");
	word_hold_a:
	assert property (ch0_tvalid && !ch0_tready |=> ch0_tvalid && $stable(ch0_tdata))
		else $error("data word dropped");
endmodule
bind mbsp_packer mbsp_packer_checker #(.WORD_W(WORD_W)) u_chk (
	.mclk(mclk), .sys_rst(sys_rst), .ctrl_k_valid(ctrl_k_valid), .ctrl_k_data(ctrl_k_data),
	.ctrl_k_ready(ctrl_k_ready), .ch0_tvalid(ch0_tvalid), .ch0_tdata(ch0_tdata),
	.ch0_tready(ch0_tready), .ch1_tvalid(ch1_tvalid), .ch2_tvalid(ch2_tvalid),
	.ch3_tvalid(ch3_tvalid), .load_req(load_req), .segment_index(segment_index),
	.tx_post_emphasis(tx_post_emphasis), .tx_swing_setting(tx_swing_setting),
	.tx_main_tap(tx_main_tap), .tx_pre_emphasis(tx_pre_emphasis),
	.xcvr_post_emphasis(xcvr_post_emphasis), .xcvr_swing_setting(xcvr_swing_setting),
	.xcvr_main_tap(xcvr_main_tap), .xcvr_pre_emphasis(xcvr_pre_emphasis)
);
`default_nettype wire

/* File: bench/mbsp_ctrl_model.sv */
// Purpose: far-side mirror controller model for channel 0
// Assumes: ready may change freely, valid held by the sender
// Notes: slow mode halves throughput and stalls the control port
`timescale 1ns/1ps
`default_nettype none
module mbsp_ctrl_model #(
	parameter int LOAD_CYC = 40
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic load_req,
	input wire logic [1:0] segment_index,
	input wire logic rx_equalizer_select,
	output logic ctrl_k_ready,
	output logic ch0_tready,
	output logic block_loading_n,
	output logic dfe_on
);
	logic [5:0] tick_q;
	int busy_q;
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			tick_q <= 6'h0;
		else
			tick_q <= tick_q + 6'h1;
	end
	// 16-cycle stalls, as long as the FIFO depth, back words up in it
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_k_ready <= 1'b0;
			ch0_tready <= 1'b0;
		end
		else
		begin
			ctrl_k_ready <= slow ? tick_q[1] : 1'b1;
			ch0_tready <= slow ? tick_q[0] : (tick_q[5:4] != 2'h3);
		end
	end
	// only segment 0 triggers the array load
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			busy_q <= 0;
		else if (load_req && segment_index == 2'h0)
			busy_q <= LOAD_CYC;
		else if (busy_q != 0)
			busy_q <= busy_q - 1;
	end
	assign block_loading_n = (busy_q == 0);
	always_ff @(posedge mclk)
		dfe_on <= rx_equalizer_select;
endmodule
`default_nettype wire

/* File: bench/mbsp_packer_tb.sv */
// Purpose: self-checking bench of the segment packer
// Assumes: full block geometry, single-channel traffic
// Notes: random rows; expected words rebuilt bit by bit
`timescale 1ns/1ps
`default_nettype none
`include "mbsp_cfg.svh"
module mbsp_packer_tb;
	logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, er, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic row_req_valid, row_rsp_valid, ctrl_k_valid, ctrl_k_ready, ch0_tvalid, ch0_tready;
	logic [7:0] row_req_index;
	logic [1023:0] row_rsp_data;
	logic [1023:0] rows [136];
	logic [191:0] ctrl_k_data, ch0_tdata;
	logic load_req, block_loading_n, rx_equalizer_select, dfe;
	logic [1:0] segment_index, row_seg;
	logic [20:0] tune;
	int seed, err_count, n_checks, n_loads, wk, dir_m, blk_m;
	int exp_seg[$];
	mbsp_packer u_mbsp_packer (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.row_req_valid(row_req_valid), .row_req_index(row_req_index), .row_req_segment(row_seg),
		.row_rsp_valid(row_rsp_valid), .row_rsp_data(row_rsp_data), .ctrl_k_valid(ctrl_k_valid),
		.ctrl_k_data(ctrl_k_data), .ctrl_k_ready(ctrl_k_ready), .ch0_tvalid(ch0_tvalid),
		.ch0_tdata(ch0_tdata), .ch0_tready(ch0_tready), .ch1_tvalid(), .ch1_tdata(),
		.ch2_tvalid(), .ch2_tdata(), .ch3_tvalid(), .ch3_tdata(), .load_req(load_req),
		.block_loading_n(block_loading_n), .segment_index(segment_index),
		.rx_equalizer_select(rx_equalizer_select), .tx_post_emphasis(tune[4:0]),
		.tx_swing_setting(tune[8:5]), .tx_main_tap(tune[15:9]), .tx_pre_emphasis(tune[20:16]),
		.xcvr_post_emphasis(), .xcvr_swing_setting(), .xcvr_main_tap(), .xcvr_pre_emphasis()
	);
	mbsp_ctrl_model u_mbsp_ctrl_model (
		.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .load_req(load_req),
		.segment_index(segment_index), .rx_equalizer_select(rx_equalizer_select),
		.ctrl_k_ready(ctrl_k_ready), .ch0_tready(ch0_tready),
		.block_loading_n(block_loading_n), .dfe_on(dfe)
	);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic check(input logic [191:0] got, input logic [191:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// rows concatenated column 0 first, in fetch order
	function automatic logic [191:0] exp_word(input int k);
		int idx;
		logic [191:0] w;
		w = '0;
		for (int b = 0; b < 192; b++)
		begin
			idx = 192 * k + b;
			if (idx < 139264)
				w[b] = rows[dir_m ? 135 - idx / 1024 : idx / 1024][idx % 1024];
		end
		return w;
	endfunction
	always @(posedge mclk)
		if (row_rsp_valid)
		begin
			if (row_req_valid)
				check(row_seg, exp_seg[0]);
			row_rsp_valid <= 1'b0;
		end
		else if (row_req_valid && $random(seed) % 2 == 0)
		begin
			row_rsp_valid <= 1'b1;
			row_rsp_data <= rows[row_req_index];
		end
	always @(posedge mclk)
		if (!sys_rst)
		begin
			if (ctrl_k_valid && ctrl_k_ready)
			begin
				check(ctrl_k_data[7:0], {blk_m[3:0], dir_m[0], 2'(exp_seg[0]), 1'b1});
				wk = 0;
			end
			if (ch0_tvalid && ch0_tready)
			begin
				if (wk == 725)
					check(ch0_tdata[63:0], exp_word(wk));
				else
					check(ch0_tdata, exp_word(wk));
				wk++;
			end
			if (load_req)
			begin
				check(wk, 726);
				check(segment_index, exp_seg.pop_front());
				n_loads++;
			end
		end
	task automatic run_block(input int d, input int b, input logic s);
		int n0;
		n0 = n_loads;
		dir_m = d;
		blk_m = b;
		slow <= s;
		exp_seg = '{3, 2, 1, 0};
		apb(1'b1, `MBSP_OFS_BLOCK, 32'(b));
		apb(1'b1, `MBSP_OFS_CTRL, 32'(5 + 2 * d));
		// a second start while busy must be ignored
		apb(1'b1, `MBSP_OFS_CTRL, 32'(5 + 2 * d));
		for (int i = 0; i < 30000 && n_loads < n0 + 4; i++)
			@(posedge mclk);
		repeat (10) @(posedge mclk);
		check(n_loads - n0, 4);
	endtask
	initial
	begin
		seed = 32'h3437A6C5;
		{psel, penable, pwrite, paddr, pwdata, row_rsp_valid, row_rsp_data, slow} = '0;
		sys_rst = 1'b1;
		tune = 21'($random(seed));
		for (int r = 0; r < 136; r++)
			for (int c = 0; c < 32; c++)
				rows[r][c * 32 +: 32] = $random(seed);
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		apb(1'b0, `MBSP_OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, `MBSP_OFS_TUNE, 32'h0);
		check(rd, {11'h0, tune});
		apb(1'b0, 12'h020, 32'h0);
		check({er, rd}, {1'b1, 32'h0});
		apb(1'b1, `MBSP_OFS_CTRL, 32'h4);
		check(rx_equalizer_select, 1'b1);
		run_block(0, 5, 1'b0);
		apb(1'b0, `MBSP_OFS_WORDS, 32'h0);
		check(rd, 32'd2904);
		// idle, segment 0 last: a start written while busy left no block behind
		apb(1'b0, `MBSP_OFS_STATUS, 32'h0);
		check(rd[2:0], 3'h0);
		check(dfe, 1'b1);
		run_block(1, 10, 1'b1);
		wrap_up();
	end
	initial
	begin
		repeat (80000) @(posedge mclk);
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
